// ---- logic/sad_pkg.sv ----
// Purpose: Constants for the system address decoder
// Assumes: 32-bit system bus address, 50 MHz system clock
// Notes:   Area and region codes, boot selection bit
package sad_pkg;
  localparam int          ADDR_W       = 32;
  localparam int          AREA_HI      = 31;
  localparam int          AREA_LO      = 28;
  localparam int          REGION_HI    = 27;
  localparam int          REGION_LO    = 20;
  localparam int          NUM_CS       = 8;
  localparam logic [3:0]  AREA_INT     = 4'h0;
  localparam logic [3:0]  AREA_EXT_LO  = 4'h1;
  localparam logic [3:0]  AREA_EXT_HI  = 4'h8;
  localparam logic [3:0]  AREA_PERIPH  = 4'hF;
  localparam logic [7:0]  REG_BOOT     = 8'h00;
  localparam logic [7:0]  REG_FLASH    = 8'h01;
  localparam logic [7:0]  REG_SRAM     = 8'h02;
  localparam logic [7:0]  REG_ROM      = 8'h03;
  localparam int          NVM_BOOT_BIT = 2;
  localparam logic        REMAP_RESET  = 1'b0;
  typedef enum logic [2:0] {
    SAD_TGT_NONE,
    SAD_TGT_FLASH,
    SAD_TGT_SRAM,
    SAD_TGT_ROM,
    SAD_TGT_EXT,
    SAD_TGT_PERIPH,
    SAD_TGT_ABORT
  } sad_target_e;
endpackage

// ---- logic/sad_area0_decode.sv ----
// Purpose: Second-level decode of area zero into 1-Mbyte regions
// Assumes: Combinational; caller registers the result
// Notes:   Regions above the fourth one report an abort
`timescale 1ns/1ps
`default_nettype none
module sad_area0_decode
(
  // Address and mode
  input  wire logic [7:0]           i_region,
  input  wire logic                 i_remap,
  input  wire logic                 i_boot_flash,
  // Result
  output var sad_pkg::sad_target_e  o_target
);
  // Boot alias follows remap first, then the boot bit
  wire sad_pkg::sad_target_e boot_tgt =
    i_remap      ? sad_pkg::SAD_TGT_SRAM :
    i_boot_flash ? sad_pkg::SAD_TGT_FLASH :
                   sad_pkg::SAD_TGT_ROM;

  // Fixed regions never move with remap
  assign o_target =
    (i_region == sad_pkg::REG_BOOT)  ? boot_tgt :
    (i_region == sad_pkg::REG_FLASH) ? sad_pkg::SAD_TGT_FLASH :
    (i_region == sad_pkg::REG_SRAM)  ? sad_pkg::SAD_TGT_SRAM :
    (i_region == sad_pkg::REG_ROM)   ? sad_pkg::SAD_TGT_ROM :
                                       sad_pkg::SAD_TGT_ABORT;
endmodule
`default_nettype wire

// ---- logic/sad_decoder.sv ----
// Purpose: First-level system address decoder
// Assumes: One access request per valid cycle, same clock as masters
// Notes:   Selects are registered, one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module sad_decoder
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  // Access request from the system bus
  input  wire logic                 i_valid,
  input  wire logic [31:0]          i_addr,
  // Configuration
  input  wire logic                 i_remap_cmd,
  input  wire logic [2:0]           i_nonvolatile_config_bit,
  // Selects
  output logic                      o_flash_sel,
  output logic                      o_sram_sel,
  output logic                      o_rom_sel,
  output logic [7:0]                o_external_chip_select,
  output logic                      o_periph_sel,
  output logic                      o_abort,
  output logic                      o_remapped
);
  // Checks further down all run on the system clock, off during reset
  default clocking chk_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  //////////////////////////////////////////////////////////////////////
  // Area decode
  wire logic [3:0] area = i_addr[sad_pkg::AREA_HI:sad_pkg::AREA_LO];
  wire logic [7:0] region =
    i_addr[sad_pkg::REGION_HI:sad_pkg::REGION_LO];
  wire logic       is_int = (area == sad_pkg::AREA_INT);
  wire logic       is_ext = (area >= sad_pkg::AREA_EXT_LO) &&
                            (area <= sad_pkg::AREA_EXT_HI);
  wire logic       is_per = (area == sad_pkg::AREA_PERIPH);
  wire logic [3:0] cs_idx = area - sad_pkg::AREA_EXT_LO;
  sad_pkg::sad_target_e int_tgt;

  logic remap_reg;
  logic boot_flash_reg;

  sad_area0_decode u_area0
  (
    .i_region     (region),
    .i_remap      (remap_reg),
    .i_boot_flash (boot_flash_reg),
    .o_target     (int_tgt)
  );

  // Next-value selects, gated by the request valid
  wire logic       flash_next = i_valid && is_int &&
                                (int_tgt == sad_pkg::SAD_TGT_FLASH);
  wire logic       sram_next  = i_valid && is_int &&
                                (int_tgt == sad_pkg::SAD_TGT_SRAM);
  wire logic       rom_next   = i_valid && is_int &&
                                (int_tgt == sad_pkg::SAD_TGT_ROM);
  wire logic [7:0] cs_next    = (i_valid && is_ext) ?
                                (8'h01 << cs_idx[2:0]) : 8'h00;
  wire logic       per_next   = i_valid && is_per;
  wire logic       abort_next = i_valid &&
    ((!is_int && !is_ext && !is_per) ||
     (is_int && int_tgt == sad_pkg::SAD_TGT_ABORT));

  //////////////////////////////////////////////////////////////////////
  // Remap latch; sticky until reset, as is the case for a remap command
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      remap_reg <= sad_pkg::REMAP_RESET;
    else if (i_remap_cmd)
      remap_reg <= 1'b1;
  end

  // Boot bit is sampled on the first clock after release, a strap
  logic boot_taken_reg;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      boot_flash_reg <= 1'b0;
      boot_taken_reg <= 1'b0;
    end
    else if (!boot_taken_reg)
    begin
      boot_flash_reg <= i_nonvolatile_config_bit[sad_pkg::NVM_BOOT_BIT];
      boot_taken_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registered selects
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_flash_sel            <= 1'b0;
      o_sram_sel             <= 1'b0;
      o_rom_sel              <= 1'b0;
      o_external_chip_select <= 8'h00;
      o_periph_sel           <= 1'b0;
      o_abort                <= 1'b0;
    end
    else
    begin
      o_flash_sel            <= flash_next;
      o_sram_sel             <= sram_next;
      o_rom_sel              <= rom_next;
      o_external_chip_select <= cs_next;
      o_periph_sel           <= per_next;
      o_abort                <= abort_next;
    end
  end

  assign o_remapped = remap_reg;

  //////////////////////////////////////////////////////////////////////
  // Checks
  // Every select and the abort as one vector, for the answer checks
  wire logic [12:0] sel_vec = {o_flash_sel, o_sram_sel, o_rom_sel,
                               o_external_chip_select, o_periph_sel,
                               o_abort};

  // Each request gets one answer; no answer without a request
  chk_one_answer: assert property (
    i_valid
      |=> $onehot(sel_vec))
    else $error("request without exactly one select");
  chk_idle_quiet: assert property (
    !i_valid
      |=> (sel_vec == 13'h0000))
    else $error("select raised without a request");

  // External areas, one chip select each
  chk_ext_cs_onehot: assert property (
    (i_valid && is_ext)
      |=> (o_external_chip_select == (8'h01 << $past(cs_idx[2:0]))))
    else $error("external select does not match area");
  chk_area_one_cs0: assert property (
    (i_valid && area == 4'h1)
      |=> o_external_chip_select[0])
    else $error("area one did not assert select zero");
  chk_area_eight_cs7: assert property (
    (i_valid && area == 4'h8)
      |=> o_external_chip_select[7])
    else $error("area eight did not assert select seven");
  chk_ext_no_abort: assert property (
    (i_valid && is_ext)
      |=> !o_abort)
    else $error("external area aborted");

  // Peripheral area and unused areas
  chk_periph_route: assert property (
    (i_valid && area == 4'hF)
      |=> (o_periph_sel && !o_abort))
    else $error("area fifteen not routed to peripherals");
  chk_unused_abort: assert property (
    (i_valid && area > 4'h8 && area < 4'hF)
      |=> (o_abort && o_external_chip_select == 8'h00))
    else $error("unused area not aborted");

  // Area zero, regions that never move
  chk_int_no_ext: assert property (
    (i_valid && is_int)
      |=> (o_external_chip_select == 8'h00 && !o_periph_sel))
    else $error("area zero leaked to an outer target");
  chk_flash_fixed: assert property (
    (i_valid && i_addr[31:20] == 12'h001)
      |=> o_flash_sel)
    else $error("flash region not selected");
  chk_sram_fixed: assert property (
    (i_valid && i_addr[31:20] == 12'h002)
      |=> o_sram_sel)
    else $error("sram region not selected");
  chk_rom_fixed: assert property (
    (i_valid && i_addr[31:20] == 12'h003)
      |=> o_rom_sel)
    else $error("rom region not selected");
  chk_area0_hole: assert property (
    (i_valid && area == 4'h0 && i_addr[27:22] != 6'h00)
      |=> o_abort)
    else $error("area zero hole not aborted");

  // Boot alias at address zero, before and after remap
  chk_zero_before_remap: assert property (
    (i_valid && i_addr[31:20] == 12'h000 && !remap_reg)
      |=> !o_sram_sel)
    else $error("sram at zero before remap");
  chk_zero_after_remap: assert property (
    (i_valid && i_addr[31:20] == 12'h000 && remap_reg)
      |=> o_sram_sel)
    else $error("sram missing at zero after remap");
  chk_boot_alias: assert property (
    (i_valid && i_addr[31:20] == 12'h000 && !remap_reg && boot_taken_reg)
      |=> (o_flash_sel == $past(boot_flash_reg)) &&
          (o_rom_sel != $past(boot_flash_reg)))
    else $error("boot alias wrong");
  chk_rom_default: assert property (
    (i_valid && i_addr[31:20] == 12'h000 && !remap_reg && !boot_flash_reg)
      |=> o_rom_sel)
    else $error("rom not at zero with boot bit clear");

  // Strap and remap state; a lost remap would move the vectors back
  chk_boot_held: assert property (
    boot_taken_reg
      |=> $stable(boot_flash_reg))
    else $error("boot strap changed after capture");
  chk_remap_set: assert property (
    i_remap_cmd
      |=> remap_reg)
    else $error("remap command not taken");
  chk_remap_sticky: assert property (
    remap_reg
      |=> remap_reg)
    else $error("remap dropped");
endmodule
`default_nettype wire

// ---- bench/sad_master_model.sv ----
// Purpose: System bus master stand-in that drives the decoder request
// Assumes: Bench changes req and addr just after a rising edge
// Notes:   A released address bus shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module sad_master_model
(
  // Bench side
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  // Decoder side
  output logic             o_valid,
  output logic [31:0]      o_addr
);
  // Idle lines must not echo the last request, or a stale decode hides
  assign o_valid = i_req;
  assign o_addr  = i_req ? i_addr : ~i_addr;
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the system address decoder
// Assumes: One request at a time, answer on the following edge
// Notes:   Expected selects are worked out from the address map
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        req = 1'b0;
  logic [31:0] addr = 32'h00000000;
  logic        i_remap_cmd = 1'b0;
  logic [2:0]  i_nonvolatile_config_bit = 3'h0;
  logic        i_valid;
  logic [31:0] i_addr;
  wire [13:0]  got;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  sad_master_model master (.i_req(req), .i_addr(addr),
    .o_valid(i_valid), .o_addr(i_addr));
  sad_decoder dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_valid(i_valid), .i_addr(i_addr), .i_remap_cmd(i_remap_cmd),
    .i_nonvolatile_config_bit(i_nonvolatile_config_bit),
    .o_flash_sel(got[12]), .o_sram_sel(got[11]), .o_rom_sel(got[10]),
    .o_external_chip_select(got[9:2]), .o_periph_sel(got[1]),
    .o_abort(got[0]), .o_remapped(got[13]));
  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard, ceiling far above the hundred or so cycles used
  initial
    forever #10 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  // Expected {remapped, flash, sram, rom, chip selects, periph, abort}
  function automatic logic [13:0] exp_sel(logic [31:0] a, logic rm,
                                          logic bt);
    logic [13:0] e;
    e = {rm, 13'h0000};
    if (a[31:28] == 4'h0 && a[27:20] == 8'h00)
      e[12:10] = rm ? 3'b010 : (bt ? 3'b100 : 3'b001);
    else if (a[31:28] == 4'h0 && a[27:20] < 8'h04)
      e[12:10] = 3'b100 >> (a[21:20] - 2'h1);
    else if (a[31:28] >= 4'h1 && a[31:28] <= 4'h8)
      e[9:2] = 8'h01 << (a[31:28] - 4'h1);
    else if (a[31:28] == 4'hF)
      e[1] = 1'b1;
    else
      e[0] = 1'b1;
    return e;
  endfunction
  task automatic cmp(input logic [13:0] exp_v);
    samples_checked++;
    if (got !== exp_v)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp_v);
    end
  endtask
  // One request, then look at the answer once it has settled
  task automatic access(input logic [31:0] a);
    @(posedge i_clk);
    req  <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    req  <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic do_reset(input logic bt);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    i_nonvolatile_config_bit <= {bt, 2'b00};
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_areas();
    for (int k = 0; k < 16; k++)
    begin
      access({k[3:0], 28'hFFFFFF0});
      cmp(exp_sel({k[3:0], 28'hFFFFFF0}, 1'b0, 1'b0));
    end
  endtask
  task automatic test_area0(input logic bt, input logic rm);
    logic [7:0] regs [6];
    regs = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hFF};
    for (int k = 0; k < 6; k++)
    begin
      access({4'h0, regs[k], 20'hABCDE});
      cmp(exp_sel({4'h0, regs[k], 20'hABCDE}, rm, bt));
    end
  endtask
  // Back-to-back requests, then the quiet cycle after the last one
  task automatic test_b2b(input logic rm);
    @(posedge i_clk);
    req  <= 1'b1;
    addr <= 32'h10000000;
    @(posedge i_clk);
    addr <= 32'hF0000000;
    @(negedge i_clk);
    cmp(exp_sel(32'h10000000, rm, 1'b0));
    @(posedge i_clk);
    req <= 1'b0;
    @(negedge i_clk);
    cmp(exp_sel(32'hF0000000, rm, 1'b0));
    @(negedge i_clk);
    cmp({rm, 13'h0000});
  endtask
  task automatic test_remap(input logic bt);
    @(posedge i_clk);
    i_remap_cmd <= 1'b1;
    @(posedge i_clk);
    i_remap_cmd <= 1'b0;
    access(32'h00000040);
    cmp(exp_sel(32'h00000040, 1'b1, bt));
    access(32'h00200040);
    cmp(exp_sel(32'h00200040, 1'b1, bt));
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    do_reset(1'b0);
    test_areas();
    test_b2b(1'b0);
    test_area0(1'b0, 1'b0);
    test_remap(1'b0);
    test_area0(1'b0, 1'b1);
    do_reset(1'b1);
    test_area0(1'b1, 1'b0);
    test_remap(1'b1);
    test_area0(1'b1, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
